// ===== hdl/frip_dev.sv
`timescale 1ns/1ps
`default_nettype none
module frip_dev
  import frip_pkg::*;
#(
  parameter int BLK_W = FRIP_BLK_W
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // link to cpu side
  frip_if.dev                   lnk,
  // flash operation control
  input  wire logic             op_start,
  input  wire frip_op_t         op_kind,
  input  wire frip_tgt_t        op_target,
  input  wire logic [BLK_W-1:0] op_block,
  input  wire logic             op_done,
  input  wire frip_mode_t       rewrite_mode,
  input  wire logic             suspend_enable,
  input  wire logic             suspend_on_interrupt_enable,
  // read permission
  input  wire logic [BLK_W-1:0] rd_block,
  output logic                  rd_allow,
  // flash core control
  output logic                  core_run
);
  typedef enum logic [2:0] {S_IDLE, S_RUN, S_SUSP_WAIT, S_SUSP, S_ABORT} frip_st_t;
  frip_st_t         st_r, st_nxt;
  frip_op_t         kind_r, kind_nxt;
  frip_tgt_t        tgt_r, tgt_nxt;
  logic [BLK_W-1:0] blk_r, blk_nxt;
  logic             req_r, req_nxt;
  logic             pend_r, pend_nxt;
  logic             hs_r, hs_nxt;
  logic             rd_r, rd_nxt;
  logic             frst_r, frst_nxt;
  logic             susp_r, susp_nxt;
  logic             busy_r, busy_nxt;
  logic             run_r, run_nxt;
  logic             dly_load, dly_done, dly_abort;
  logic [FRIP_CNT_W-1:0] dly_cnt;
  logic             erase_susp_ok;
  // ==========================================================
  // shared delay counter for suspend latency and restart
  frip_delay #(.W(FRIP_CNT_W)) u_dly (
    .clk   (clk),
    .nrst  (nrst),
    .load  (dly_load),
    .cnt   (dly_cnt),
    .abort (dly_abort),
    .done  (dly_done)
  );
  assign erase_susp_ok = (kind_r == FRIP_OP_ERASE) && suspend_enable;
  // ==========================================================
  // sequencing
  always_comb
  begin
    st_nxt       = st_r;
    kind_nxt     = kind_r;
    tgt_nxt      = tgt_r;
    blk_nxt      = blk_r;
    req_nxt      = req_r;
    pend_nxt     = pend_r;
    hs_nxt       = 1'b0;
    dly_load     = 1'b0;
    dly_abort    = 1'b0;
    dly_cnt      = FRIP_CNT_W'(FRIP_SUSPEND_CYC);
    if (lnk.susp_req_wr)
      req_nxt = lnk.susp_req_wdata;
    unique case (st_r)
      S_IDLE:
      begin
        req_nxt = 1'b0;
        if (lnk.maskable_ack || lnk.swexc_ack || lnk.nonmask_ack)
          hs_nxt = 1'b1;
        if (pend_r)
        begin
          pend_nxt = 1'b0;
          hs_nxt   = 1'b1;
        end
        if (op_start && op_kind != FRIP_OP_IDLE)
        begin
          st_nxt   = S_RUN;
          kind_nxt = op_kind;
          tgt_nxt  = op_target;
          blk_nxt  = op_block;
        end
      end
      S_RUN, S_SUSP_WAIT, S_SUSP:
      begin
        if (tgt_r == FRIP_TGT_ROM && rewrite_mode == FRIP_MODE_RAM && lnk.nonmask_ack)
        begin
          st_nxt   = S_ABORT;
          dly_load = 1'b1;
          dly_cnt  = FRIP_CNT_W'(FRIP_RESTART_CYC);
        end
        else
        begin
          if (lnk.nonmask_ack || lnk.swexc_ack)
            hs_nxt = 1'b1;
          if (lnk.maskable_ack)
          begin
            if (tgt_r == FRIP_TGT_DATA)
            begin
              hs_nxt = 1'b1;
              if (erase_susp_ok && suspend_on_interrupt_enable)
                req_nxt = 1'b1;
            end
            else if (rewrite_mode == FRIP_MODE_ROM)
            begin
              if (erase_susp_ok)
                req_nxt = 1'b1;
              else
                pend_nxt = 1'b1;
            end
            else
              hs_nxt = 1'b1;
          end
          if (st_r == S_RUN && op_done)
          begin
            st_nxt = S_IDLE;
            req_nxt = 1'b0;
          end
          else if (st_r == S_RUN && req_nxt && erase_susp_ok)
          begin
            st_nxt   = S_SUSP_WAIT;
            dly_load = 1'b1;
          end
          else if (st_r == S_SUSP_WAIT && dly_done && req_nxt)
          begin
            st_nxt = S_SUSP;
            if (tgt_r == FRIP_TGT_ROM)
              hs_nxt = 1'b1;
          end
          else if (st_r != S_RUN && !req_nxt)
          begin
            st_nxt    = S_RUN;
            // a cancelled wait must not leave a stale countdown behind
            dly_abort = (st_r == S_SUSP_WAIT);
          end
        end
      end
      S_ABORT:
      begin
        req_nxt = 1'b0;
        if (dly_done)
        begin
          st_nxt = S_IDLE;
          hs_nxt = 1'b1;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    rd_nxt = (st_nxt == S_IDLE)
             || (st_nxt == S_SUSP && rd_block != blk_nxt);
    // status flags registered from the next state, same timing as a decode
    frst_nxt = (st_nxt == S_ABORT);
    susp_nxt = (st_nxt == S_SUSP);
    busy_nxt = (st_nxt != S_IDLE);
    run_nxt  = (st_nxt == S_RUN);
  end
  // all outputs come straight from these flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r       <= S_IDLE;
      kind_r     <= FRIP_OP_IDLE;
      tgt_r      <= FRIP_TGT_DATA;
      blk_r      <= '0;
      req_r      <= 1'b0;
      pend_r     <= 1'b0;
      hs_r       <= 1'b0;
      rd_r       <= 1'b1;
      frst_r     <= 1'b0;
      susp_r     <= 1'b0;
      busy_r     <= 1'b0;
      run_r      <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      kind_r     <= kind_nxt;
      tgt_r      <= tgt_nxt;
      blk_r      <= blk_nxt;
      req_r      <= req_nxt;
      pend_r     <= pend_nxt;
      hs_r       <= hs_nxt;
      rd_r       <= rd_nxt;
      frst_r     <= frst_nxt;
      susp_r     <= susp_nxt;
      busy_r     <= busy_nxt;
      run_r      <= run_nxt;
    end
  end
  // ==========================================================
  // outputs
  assign lnk.handler_start = hs_r;
  assign lnk.irq_pending   = pend_r;
  assign lnk.flash_reset   = frst_r;
  assign lnk.suspended     = susp_r;
  assign lnk.busy          = busy_r;
  assign lnk.susp_req      = req_r;
  assign rd_allow          = rd_r;
  assign core_run          = run_r;
endmodule
`default_nettype wire

// ===== hdl/frip_pkg.sv
package frip_pkg;
  // ==========================================================
  // operation and mode encodings
  typedef enum logic [1:0] {FRIP_OP_IDLE, FRIP_OP_ERASE, FRIP_OP_PROG} frip_op_t;
  typedef enum logic {FRIP_TGT_DATA, FRIP_TGT_ROM} frip_tgt_t;
  typedef enum logic {FRIP_MODE_RAM, FRIP_MODE_ROM} frip_mode_t;
  // ==========================================================
  // timing
  localparam int FRIP_CLK_MHZ            = 125;
  localparam int FRIP_SUSPEND_LATENCY_NS = 200;  // suspend_latency, plain default
  localparam int FRIP_SUSPEND_CYC =
    (FRIP_SUSPEND_LATENCY_NS * FRIP_CLK_MHZ + 999) / 1000;
  localparam int FRIP_RESTART_NS  = 400;         // flash restart after abort
  localparam int FRIP_RESTART_CYC = (FRIP_RESTART_NS * FRIP_CLK_MHZ + 999) / 1000;
  localparam int FRIP_CNT_W = 12;
  localparam logic [FRIP_CNT_W-1:0] FRIP_CNT_ZERO = 12'h000;
  localparam int FRIP_BLK_W = 4;
endpackage

// ===== hdl/frip_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the flash sequencer and the cpu/interrupt controller side
interface frip_if;
  import frip_pkg::*;
  logic                  maskable_ack;   // maskable interrupt acknowledged
  logic                  nonmask_ack;    // non-maskable source acknowledged
  logic                  swexc_ack;      // software-type exception taken
  logic                  handler_start;  // device lets handler run (pulse)
  logic                  irq_pending;    // maskable held on standby
  logic                  flash_reset;    // abort in progress
  logic                  suspended;      // erase suspended
  logic                  busy;           // operation running
  logic                  susp_req_wr;    // software write strobe
  logic                  susp_req_wdata; // value for erase_suspend_request
  logic                  susp_req;       // current erase_suspend_request
  modport dev (input maskable_ack, nonmask_ack, swexc_ack, susp_req_wr, susp_req_wdata,
               output handler_start, irq_pending, flash_reset, suspended, busy, susp_req);
  modport host (output maskable_ack, nonmask_ack, swexc_ack, susp_req_wr, susp_req_wdata,
                input handler_start, irq_pending, flash_reset, suspended, busy, susp_req);
endinterface
`default_nettype wire

// ===== hdl/frip_delay.sv
`timescale 1ns/1ps
`default_nettype none
// one-shot down counter: done pulses after load plus cnt cycles
module frip_delay
  import frip_pkg::*;
#(
  parameter int W = FRIP_CNT_W
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] cnt,
  input  wire logic         abort,
  output logic              done
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic         run_r, run_nxt, done_r, done_nxt;
  // ==========================================================
  // counting
  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (abort)
    begin
      run_nxt = 1'b0;
    end
    else if (load)
    begin
      cnt_nxt = cnt;
      run_nxt = 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r <= W'(1))
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end
  assign done = done_r;
endmodule
`default_nettype wire

// ===== hdl/frip_host.sv
`timescale 1ns/1ps
`default_nettype none
// cpu side: forwards acknowledges, writes the suspend request bit
module frip_host
  import frip_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // link to flash sequencer
  frip_if.host      lnk,
  // user side
  input  wire logic maskable_in,
  input  wire logic nonmask_in,
  input  wire logic swexc_in,
  input  wire logic sw_suspend,
  input  wire logic sw_resume,
  output logic      handler_run,
  output logic      flash_busy
);
  logic ma_r, na_r, sa_r, wr_r, wd_r, hr_r, fb_r;
  logic ma_nxt, na_nxt, sa_nxt, wr_nxt, wd_nxt, hr_nxt, fb_nxt;
  // ==========================================================
  // request forwarding; exceptions passed on one cycle later, even while a flash reset runs
  always_comb
  begin
    ma_nxt = maskable_in;
    na_nxt = nonmask_in;
    sa_nxt = swexc_in;
    wr_nxt = sw_suspend || sw_resume;
    wd_nxt = sw_suspend;
    hr_nxt = lnk.handler_start;
    fb_nxt = lnk.busy || lnk.flash_reset;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ma_r <= 1'b0;
      na_r <= 1'b0;
      sa_r <= 1'b0;
      wr_r <= 1'b0;
      wd_r <= 1'b0;
      hr_r <= 1'b0;
      fb_r <= 1'b0;
    end
    else
    begin
      ma_r <= ma_nxt;
      na_r <= na_nxt;
      sa_r <= sa_nxt;
      wr_r <= wr_nxt;
      wd_r <= wd_nxt;
      hr_r <= hr_nxt;
      fb_r <= fb_nxt;
    end
  end
  assign lnk.maskable_ack   = ma_r;
  assign lnk.nonmask_ack    = na_r;
  assign lnk.swexc_ack      = sa_r;
  assign lnk.susp_req_wr    = wr_r;
  assign lnk.susp_req_wdata = wd_r;
  assign handler_run        = hr_r;
  assign flash_busy         = fb_r;
endmodule
`default_nettype wire

// ===== bench/frip_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link between the flash sequencer and the cpu side
module frip_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link signals
  input wire logic maskable_ack,
  input wire logic swexc_ack,
  input wire logic handler_start,
  input wire logic irq_pending,
  input wire logic flash_reset,
  input wire logic suspended,
  input wire logic busy,
  input wire logic susp_req_wr,
  input wire logic susp_req_wdata,
  input wire logic susp_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // suspend and resume
  AST_SUSP_REQ: assert property ($rose(suspended) |-> susp_req)
    else $error("suspend without request");
  // the latency keeps suspended low for a while after the request; core_run falls together with the request for an erase with suspend_enable set
  AST_SUSP_LAT: assert property ($rose(susp_req) |=> !suspended[*8])
    else $error("suspend came too early");
  AST_RESUME: assert property
    (susp_req_wr && !susp_req_wdata && suspended && !maskable_ack |-> ##[1:2] !suspended)
    else $error("erase did not resume");
  AST_SWEXC_NO_AUTO: assert property
    (swexc_ack && !susp_req && !susp_req_wr && !maskable_ack |=> !susp_req)
    else $error("exception set suspend request");
  // ==========================================================
  // handler release
  AST_IDLE_HANDLER: assert property
    (maskable_ack && !busy && !flash_reset && !irq_pending |=> handler_start)
    else $error("idle handler not started");
  AST_PEND_RELEASE: assert property ($fell(irq_pending) |-> ##[0:2] handler_start)
    else $error("pending request not serviced");
  AST_ABORT_HOLD: assert property ($rose(flash_reset) |=> flash_reset[*8])
    else $error("abort too short");
  AST_ABORT_HANDLER: assert property ($fell(flash_reset) |-> ##[0:3] handler_start)
    else $error("no handler after restart");
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frip_pkg::*;
  logic       clk, nrst, op_start, op_done, se, soie, mi, ni, si, ss, sr;
  logic       rd_allow, core_run, handler_run, flash_busy;
  frip_op_t   kind;
  frip_tgt_t  tgt;
  frip_mode_t mode;
  logic [3:0] blk, rdb;
  int         fail_count, comparisons, n_hand, h0, seed;
  logic       q[$];
  frip_if lnk ();
  frip_dev frip_dev_inst (.clk(clk), .nrst(nrst), .lnk(lnk), .op_start(op_start),
    .op_kind(kind), .op_target(tgt), .op_block(blk), .op_done(op_done), .rewrite_mode(mode),
    .suspend_enable(se), .suspend_on_interrupt_enable(soie), .rd_block(rdb),
    .rd_allow(rd_allow), .core_run(core_run));
  frip_host frip_host_inst (.clk(clk), .nrst(nrst), .lnk(lnk), .maskable_in(mi),
    .nonmask_in(ni), .swexc_in(si), .sw_suspend(ss), .sw_resume(sr),
    .handler_run(handler_run), .flash_busy(flash_busy));
  frip_chk frip_chk_inst (.clk(clk), .nrst(nrst), .maskable_ack(lnk.maskable_ack),
    .swexc_ack(lnk.swexc_ack), .handler_start(lnk.handler_start),
    .irq_pending(lnk.irq_pending), .flash_reset(lnk.flash_reset),
    .suspended(lnk.suspended), .busy(lnk.busy), .susp_req_wr(lnk.susp_req_wr),
    .susp_req_wdata(lnk.susp_req_wdata), .susp_req(lnk.susp_req));
  // ==========================================================
  // helpers
  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = lnk.busy;
      1: pick = lnk.suspended;
      2: pick = lnk.irq_pending;
      default: pick = lnk.flash_reset;
    endcase
  endfunction
  // bounded wait, a hang ends the run as a mismatch
  task automatic wait_for(input int sel, input logic val);
    int n;
    n = 0;
    while (pick(sel) !== val && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      $display("FAIL %0t wait ran out", $time);
      final_report();
    end
  endtask
  task automatic pulse(input int sel);
    @(negedge clk);
    case (sel)
      0: mi = 1'b1;
      1: ni = 1'b1;
      2: si = 1'b1;
      3: ss = 1'b1;
      default: sr = 1'b1;
    endcase
    @(negedge clk);
    {mi, ni, si, ss, sr} = 5'h00;
  endtask
  task automatic start(input frip_mode_t m, input frip_op_t k, input frip_tgt_t t,
                       input logic e, input logic a);
    @(negedge clk);
    mode = m;
    kind = k;
    tgt  = t;
    se   = e;
    soie = a;
    blk = 4'($random(seed));
    op_start = 1'b1;
    @(negedge clk);
    op_start = 1'b0;
    wait_for(0, 1'b1);
  endtask
  task automatic finish_op(input string name);
    @(negedge clk);
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    wait_for(0, 1'b0);
    $display("test %0s done", name);
  endtask
  // clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // scoreboard: each handler run takes the oldest expected suspend state
  always @(negedge clk)
    if (handler_run === 1'b1)
    begin
      n_hand++;
      check(q.size() != 0, 1'b1);
      if (q.size() != 0)
        check(lnk.suspended, q.pop_front());
    end
  // ==========================================================
  // main sequence
  initial
  begin
    {nrst, op_start, op_done, se, soie, mi, ni, si, ss, sr} = 10'h000;
    mode = FRIP_MODE_ROM;
    kind = FRIP_OP_IDLE;
    tgt  = FRIP_TGT_DATA;
    {blk, rdb} = 8'h00;
    {seed, fail_count, comparisons, n_hand} = {32'h5661, 96'h0};
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    check(rd_allow, 1'b1);
    // random done strobes and resume writes while idle must change nothing
    repeat (8)
    begin
      @(negedge clk);
      op_done = 1'($random(seed));
      sr      = 1'($random(seed));
    end
    @(negedge clk);
    {op_done, sr} = 2'h0;
    repeat (3) @(negedge clk);
    check(lnk.busy, 1'b0);
    check(lnk.susp_req, 1'b0);
    $display("test idle_noise done");
    q.push_back(1'b0);
    pulse(0);
    start(FRIP_MODE_ROM, FRIP_OP_ERASE, FRIP_TGT_DATA, 1'b1, 1'b1);
    q.push_back(1'b0);
    pulse(0);
    wait_for(1, 1'b1);
    check(lnk.susp_req, 1'b1);
    check(core_run, 1'b0);
    rdb = blk;
    repeat (2) @(negedge clk);
    check(rd_allow, 1'b0);
    rdb = blk + 4'h1;
    repeat (2) @(negedge clk);
    check(rd_allow, 1'b1);
    pulse(4);
    wait_for(1, 1'b0);
    check(core_run, 1'b1);
    finish_op("auto_suspend");
    // exception never suspends by itself, software does it
    start(FRIP_MODE_RAM, FRIP_OP_ERASE, FRIP_TGT_DATA, 1'b1, 1'b0);
    q.push_back(1'b0);
    pulse(2);
    repeat (40) @(negedge clk);
    check(lnk.suspended, 1'b0);
    pulse(3);
    wait_for(1, 1'b1);
    pulse(4);
    wait_for(1, 1'b0);
    finish_op("manual_suspend");
    start(FRIP_MODE_ROM, FRIP_OP_PROG, FRIP_TGT_DATA, 1'b1, 1'b1);
    q.push_back(1'b0);
    pulse(0);
    repeat (40) @(negedge clk);
    check(lnk.suspended, 1'b0);
    check(core_run, 1'b1);
    finish_op("data_program");
    // rom operation in second mode holds the request back
    start(FRIP_MODE_ROM, FRIP_OP_PROG, FRIP_TGT_ROM, 1'b0, 1'b1);
    q.push_back(1'b0);
    h0 = n_hand;
    pulse(0);
    wait_for(2, 1'b1);
    repeat (10) @(negedge clk);
    check(n_hand == h0, 1'b1);
    finish_op("rom_pending");
    start(FRIP_MODE_ROM, FRIP_OP_ERASE, FRIP_TGT_ROM, 1'b1, 1'b1);
    q.push_back(1'b1);
    pulse(0);
    wait_for(1, 1'b1);
    repeat (6) @(negedge clk);
    pulse(4);
    wait_for(1, 1'b0);
    finish_op("rom_suspend");
    start(FRIP_MODE_RAM, FRIP_OP_ERASE, FRIP_TGT_ROM, 1'b1, 1'b1);
    // vector placed in ram: the handler runs while the rom erase goes on
    q.push_back(1'b0);
    pulse(0);
    repeat (4) @(negedge clk);
    check(lnk.busy, 1'b1);
    q.push_back(1'b0);
    pulse(1);
    wait_for(3, 1'b1);
    check(flash_busy, 1'b1);
    wait_for(3, 1'b0);
    repeat (6) @(negedge clk);
    check(lnk.busy, 1'b0);
    check(flash_busy, 1'b0);
    check(q.size() == 0, 1'b1);
    $display("test abort done");
    final_report();
  end
endmodule
`default_nettype wire
